// *** shared/tms_pkg.sv ***
// Constants, register map and mode encodings for the split-capable timer
package tms_pkg;
    // Register addresses and pages
    localparam logic [7:0] TMS_ADDR_MODE_EXT = 8'h93;
    localparam logic [7:0] TMS_ADDR_AUX_ROUTE = 8'hA4;
    localparam logic [7:0] TMS_ADDR_CTRL = 8'hC8;
    localparam logic [7:0] TMS_ADDR_MODE = 8'hC9;
    localparam logic [7:0] TMS_ADDR_RCAP_L = 8'hCA;
    localparam logic [7:0] TMS_ADDR_RCAP_H = 8'hCB;
    localparam logic [7:0] TMS_ADDR_CNT_L = 8'hCC;
    localparam logic [7:0] TMS_ADDR_CNT_H = 8'hCD;
    localparam logic TMS_PAGE_0 = 1'b0;
    localparam logic TMS_PAGE_1 = 1'b1;
    localparam logic [7:0] TMS_REG_RESET = 8'h00;
    // Timer mode register fields
    localparam int TMS_M_SPLIT = 7;
    localparam int TMS_M_LCLK0 = 6;
    localparam int TMS_M_RISE = 5;
    localparam int TMS_M_CKMID = 4;
    localparam int TMS_M_LRUN = 3;
    localparam int TMS_M_LAUTO = 2;
    localparam int TMS_M_CKOE = 1;
    localparam int TMS_M_MS0 = 0;
    // Extended mode register fields
    localparam int TMS_X_LCLK1 = 7;
    localparam int TMS_X_IGN = 6;
    localparam int TMS_X_ALIAS = 5;
    localparam int TMS_X_CKHI = 4;
    localparam int TMS_X_MS1 = 3;
    localparam int TMS_X_CAPSRC = 0;
    // Control register fields
    localparam int TMS_C_OVF = 7;
    localparam int TMS_C_EXTF = 6;
    localparam int TMS_C_RXCLK = 5;
    localparam int TMS_C_TXCLK = 4;
    localparam int TMS_C_FALL = 3;
    localparam int TMS_C_RUN = 2;
    localparam int TMS_C_CT = 1;
    localparam int TMS_C_CPRL = 0;
    // Pin routing field
    localparam int TMS_A_ROUTE = 6;
    // Core clock divide by twelve prescaler
    localparam int TMS_DIV_RATIO = 12;
    localparam logic [3:0] TMS_DIV_LAST = 4'(TMS_DIV_RATIO - 1);
    // Operating modes {capture_reload_sel, mode_sel0}
    typedef enum logic [1:0] {
        TMS_AUTO_RELOAD = 2'b00,
        TMS_RELOAD_EXT = 2'b01,
        TMS_CAPTURE = 2'b10,
        TMS_CAPTURE_ZERO = 2'b11
    } tms_mode_t;
endpackage

// *** logic/tms_timer.sv ***
// Split-capable 16-bit timer with mode, clock, capture source and pin routing
`timescale 1ns/1ps
module tms_timer (
    input wire logic clk, // System clock, 10 MHz
    input wire logic arst_n, // Async reset, active low
    input wire logic sfr_page, // Register page select
    input wire logic [7:0] sfr_addr, // Register address
    input wire logic sfr_wr, // Register write strobe
    input wire logic sfr_rd, // Register read strobe
    input wire logic [7:0] sfr_wdata, // Register write data
    output logic [7:0] sfr_rdata, // Read data, one cycle after strobe
    input wire logic [7:0] port_pin_in, // Pin pairs: clock pin even, trigger odd
    output logic [7:0] port_pin_out, // Pin output levels
    output logic [7:0] port_pin_oe, // Pin output enables
    input wire logic serial1_brg_overflow, // Serial 1 baud overflow pulse
    input wire logic ext_int0_event, // External interrupt 0 event pulse
    input wire logic ext_int2_event, // External interrupt 2 event
    input wire logic timer0_overflow, // Timer 0 overflow pulse
    input wire logic comparator0_event, // Comparator 0 event pulse
    input wire logic keypad_event, // Keypad event
    input wire logic serial0_rx, // Serial 0 receive line
    input wire logic serial1_rx, // Serial 1 receive line
    input wire logic comparator0_output, // Comparator 0 level
    input wire logic comparator1_output, // Comparator 1 level
    input wire logic twowire_clock_line, // Two-wire clock line
    output logic timer_overflow, // Overflow pulse to peripherals
    output logic rx_clock_sel, // Serial 0 receive clock from this timer
    output logic tx_clock_sel, // Serial 0 transmit clock from this timer
    output logic timer_irq // Timer interrupt request, level
);
    import tms_pkg::*;

    logic [7:0] mode_q, mode_d, mode_ext_q, mode_ext_d, aux_q, aux_d;
    logic [7:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
    logic lovf_flag_q, lovf_flag_d, lirq_en_q, lirq_en_d;
    logic [15:0] cnt_q, cnt_d, rcap_q, rcap_d;
    logic [3:0] div_q, div_d;
    logic ckout_q, ckout_d, ovf_out_q, ovf_out_d;
    logic [7:0] trig_s1_q, trig_s2_q;
    logic trig_prev_q, pin_s1_q, pin_s2_q, pin_prev_q;
    logic [7:0] trig_raw;
    logic [1:0] route;
    logic split, lrun, run, ser0, reload_en, div_tick, pin_tick;
    logic trig_now, rise, fall, ext_evt, cap_evt;
    logic low_tick, high_tick, low_inc, high_inc, low_ovf, high_ovf, ovf_evt;
    logic wr_cnt_l, wr_cnt_h, wr_rcap_l, wr_rcap_h, wr_ctrl, auto_clr;
    tms_mode_t mode;

    // Write decode per register
    function automatic logic wr_at(input logic pg, input logic [7:0] ad);
        wr_at = sfr_wr && (sfr_page == pg) && (sfr_addr == ad);
    endfunction

    assign wr_cnt_l = wr_at(TMS_PAGE_0, TMS_ADDR_CNT_L);
    assign wr_cnt_h = wr_at(TMS_PAGE_0, TMS_ADDR_CNT_H);
    assign wr_rcap_l = wr_at(TMS_PAGE_0, TMS_ADDR_RCAP_L);
    assign wr_rcap_h = wr_at(TMS_PAGE_0, TMS_ADDR_RCAP_H);
    assign wr_ctrl = wr_at(TMS_PAGE_0, TMS_ADDR_CTRL);

    // Decoded control fields
    assign split = mode_q[TMS_M_SPLIT];
    assign lrun = mode_q[TMS_M_LRUN];
    assign run = ctrl_q[TMS_C_RUN];
    assign ser0 = ctrl_q[TMS_C_RXCLK] | ctrl_q[TMS_C_TXCLK];
    assign mode = tms_mode_t'({ctrl_q[TMS_C_CPRL], mode_q[TMS_M_MS0]});
    assign reload_en = ~ctrl_q[TMS_C_CPRL];
    assign route = aux_q[TMS_A_ROUTE +: 2];
    assign rx_clock_sel = ctrl_q[TMS_C_RXCLK];
    assign tx_clock_sel = ctrl_q[TMS_C_TXCLK];

    // Trigger candidates, index equals capture source code
    assign trig_raw = {twowire_clock_line, comparator1_output, comparator0_output,
                       serial1_rx, ext_int2_event, keypad_event, serial0_rx,
                       port_pin_in[{route, 1'b1}]};

    // Synchronisers; only second stage feeds edge logic
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_s1_q <= 8'h00;
            trig_s2_q <= 8'h00;
            trig_prev_q <= 1'b0;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            trig_s1_q <= trig_raw;
            trig_s2_q <= trig_s1_q;
            trig_prev_q <= trig_now;
            pin_s1_q <= port_pin_in[{route, 1'b0}];
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    // Edge events from the selected trigger and count pin
    assign trig_now = trig_s2_q[mode_ext_q[TMS_X_CAPSRC +: 3]];
    assign rise = trig_now & ~trig_prev_q;
    assign fall = ~trig_now & trig_prev_q;
    assign ext_evt = (rise & mode_q[TMS_M_RISE]) | (fall & ctrl_q[TMS_C_FALL]);
    assign cap_evt = ext_evt & ~ser0;
    assign pin_tick = pin_prev_q & ~pin_s2_q;
    assign div_tick = (div_q == TMS_DIV_LAST);

    // Low byte clock select
    always_comb begin
        unique case ({mode_ext_q[TMS_X_LCLK1], mode_q[TMS_M_LCLK0]})
            2'b00: low_tick = div_tick;
            2'b01: low_tick = 1'b1;
            2'b10: low_tick = serial1_brg_overflow;
            2'b11: low_tick = ext_int0_event;
        endcase
    end

    assign low_inc = split & lrun & low_tick;
    assign low_ovf = low_inc & (cnt_q[7:0] == 8'hFF);

    // Sixteen-bit or high byte clock select
    always_comb begin
        unique case ({mode_ext_q[TMS_X_CKHI], mode_q[TMS_M_CKMID], ctrl_q[TMS_C_CT]})
            3'b000: high_tick = div_tick;
            3'b001: high_tick = pin_tick;
            3'b010: high_tick = 1'b1;
            3'b011: high_tick = split ? low_ovf : ext_int0_event;
            3'b100: high_tick = serial1_brg_overflow;
            3'b101: high_tick = timer0_overflow;
            3'b110: high_tick = comparator0_event;
            3'b111: high_tick = keypad_event;
        endcase
    end

    assign high_inc = run & high_tick;
    assign high_ovf = high_inc & (split ? (cnt_q[15:8] == 8'hFF) : (cnt_q == 16'hFFFF));
    assign ovf_evt = split ? low_ovf : high_ovf;
    assign auto_clr = mode_q[TMS_M_LAUTO] &
                      ((reload_en & high_ovf) | (~reload_en & cap_evt));

    // Counter and reload/capture next values
    always_comb begin
        cnt_d = cnt_q;
        rcap_d = rcap_q;
        if (split) begin
            if (low_inc) begin
                cnt_d[7:0] = low_ovf ? (reload_en ? rcap_q[7:0] : 8'h00) : cnt_q[7:0] + 8'h01;
            end
            if (high_inc) begin
                cnt_d[15:8] = high_ovf ? (reload_en ? rcap_q[15:8] : 8'h00)
                                       : cnt_q[15:8] + 8'h01;
            end
        end else if (high_inc) begin
            cnt_d = high_ovf ? (reload_en ? rcap_q : 16'h0000) : cnt_q + 16'h0001;
        end
        if (cap_evt) begin
            unique case (mode)
                TMS_AUTO_RELOAD: cnt_d = cnt_d;
                TMS_RELOAD_EXT: cnt_d = rcap_q;
                TMS_CAPTURE: rcap_d = cnt_q;
                TMS_CAPTURE_ZERO: begin
                    rcap_d = cnt_q;
                    cnt_d = 16'h0000;
                end
            endcase
        end
        // Software writes win over counting
        if (wr_cnt_l) cnt_d[7:0] = sfr_wdata;
        if (wr_cnt_h) cnt_d[15:8] = sfr_wdata;
        if (wr_rcap_l) rcap_d[7:0] = sfr_wdata;
        if (wr_rcap_h) rcap_d[15:8] = sfr_wdata;
    end

    // Control registers; hardware set wins over software clear
    always_comb begin
        mode_d = wr_at(TMS_PAGE_0, TMS_ADDR_MODE) ? sfr_wdata : mode_q;
        mode_ext_d = wr_at(TMS_PAGE_1, TMS_ADDR_MODE_EXT) ? sfr_wdata : mode_ext_q;
        aux_d = wr_at(TMS_PAGE_1, TMS_ADDR_AUX_ROUTE) ? sfr_wdata : aux_q;
        ctrl_d = ctrl_q;
        lovf_flag_d = lovf_flag_q;
        lirq_en_d = lirq_en_q;
        if (wr_ctrl) begin
            ctrl_d = {sfr_wdata[7:6], ctrl_q[5:4], sfr_wdata[3:0]};
            if (mode_ext_q[TMS_X_ALIAS]) begin
                lovf_flag_d = sfr_wdata[TMS_C_RXCLK];
                lirq_en_d = sfr_wdata[TMS_C_TXCLK];
            end else begin
                ctrl_d[5:4] = sfr_wdata[5:4];
            end
        end
        if (auto_clr) mode_d[TMS_M_LRUN] = 1'b0;
        if (high_ovf && !ser0) ctrl_d[TMS_C_OVF] = 1'b1;
        if (ext_evt) ctrl_d[TMS_C_EXTF] = 1'b1;
        if (low_ovf) lovf_flag_d = 1'b1;
    end

    // Prescaler, clock-out toggle and overflow pulse
    always_comb begin
        div_d = div_tick ? 4'h0 : div_q + 4'h1;
        ckout_d = ckout_q ^ ovf_evt;
        ovf_out_d = ovf_evt;
    end

    // Registered read data; unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_rd) begin
            rdata_d = 8'h00;
            if (sfr_page == TMS_PAGE_0) begin
                unique case (sfr_addr)
                    TMS_ADDR_CTRL: rdata_d = {ctrl_q[7:6], mode_ext_q[TMS_X_ALIAS] ?
                                              {lovf_flag_q, lirq_en_q} : ctrl_q[5:4],
                                              ctrl_q[3:0]};
                    TMS_ADDR_MODE: rdata_d = mode_q;
                    TMS_ADDR_RCAP_L: rdata_d = rcap_q[7:0];
                    TMS_ADDR_RCAP_H: rdata_d = rcap_q[15:8];
                    TMS_ADDR_CNT_L: rdata_d = cnt_q[7:0];
                    TMS_ADDR_CNT_H: rdata_d = cnt_q[15:8];
                    default: rdata_d = 8'h00;
                endcase
            end else begin
                unique case (sfr_addr)
                    TMS_ADDR_MODE_EXT: rdata_d = mode_ext_q;
                    TMS_ADDR_AUX_ROUTE: rdata_d = aux_q;
                    default: rdata_d = 8'h00;
                endcase
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= TMS_REG_RESET;
            mode_ext_q <= TMS_REG_RESET;
            aux_q <= TMS_REG_RESET;
            ctrl_q <= TMS_REG_RESET;
            lovf_flag_q <= 1'b0;
            lirq_en_q <= 1'b0;
            cnt_q <= 16'h0000;
            rcap_q <= 16'h0000;
            div_q <= 4'h0;
            ckout_q <= 1'b0;
            ovf_out_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            mode_q <= mode_d;
            mode_ext_q <= mode_ext_d;
            aux_q <= aux_d;
            ctrl_q <= ctrl_d;
            lovf_flag_q <= lovf_flag_d;
            lirq_en_q <= lirq_en_d;
            cnt_q <= cnt_d;
            rcap_q <= rcap_d;
            div_q <= div_d;
            ckout_q <= ckout_d;
            ovf_out_q <= ovf_out_d;
            rdata_q <= rdata_d;
        end
    end

    // Clock-out onto the clock pin of the routed pair
    always_comb begin
        port_pin_out = 8'h00;
        port_pin_oe = 8'h00;
        port_pin_out[{route, 1'b0}] = ckout_q;
        port_pin_oe[{route, 1'b0}] = mode_q[TMS_M_CKOE];
    end

    assign sfr_rdata = rdata_q;
    assign timer_overflow = ovf_out_q;
    assign timer_irq = (ctrl_q[TMS_C_OVF] & ~mode_ext_q[TMS_X_IGN]) | ctrl_q[TMS_C_EXTF] |
                       (lovf_flag_q & lirq_en_q);

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_CARRY_16: assert property (!split && high_inc && cnt_q[7:0] == 8'hFF
        && !high_ovf && !cap_evt && !wr_cnt_l && !wr_cnt_h |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("16-bit carry into high byte missing");
    AST_LOW_FAST: assert property (split && lrun && !mode_ext_q[TMS_X_LCLK1]
        && mode_q[TMS_M_LCLK0] && cnt_q[7:0] != 8'hFF && !cap_evt && !wr_cnt_l
        |=> cnt_q[7:0] == $past(cnt_q[7:0]) + 8'h01)
        else $error("low byte not counting at core clock");
    AST_RISE_CAPTURE: assert property (rise && mode_q[TMS_M_RISE] && !ser0
        && mode == TMS_CAPTURE && !wr_rcap_l && !wr_rcap_h |=> rcap_q == $past(cnt_q))
        else $error("rising trigger did not capture");
    AST_SER0_NO_CAPTURE: assert property (ext_evt && ser0 && !wr_rcap_l && !wr_rcap_h
        |=> rcap_q == $past(rcap_q) && ctrl_q[TMS_C_EXTF] && timer_irq)
        else $error("serial-clock trigger handling wrong");
    AST_LOW_STOP: assert property (!(split && lrun) && !cap_evt && !wr_cnt_l
        && !(high_inc && !split) |=> cnt_q[7:0] == $past(cnt_q[7:0]))
        else $error("low byte moved while stopped");
    AST_AUTOCLEAR: assert property (mode_q[TMS_M_LAUTO] && reload_en && high_ovf
        |=> !mode_q[TMS_M_LRUN])
        else $error("low run not cleared on high overflow");
    AST_CLKOUT_PIN: assert property (mode_q[TMS_M_CKOE] |-> port_pin_oe[{route, 1'b0}]
        && $countones(port_pin_oe) == 1)
        else $error("clock-out not driven on routed pin");
    AST_ZERO_MODE: assert property (cap_evt && mode == TMS_CAPTURE_ZERO && !wr_cnt_l
        && !wr_cnt_h |=> cnt_q == 16'h0000)
        else $error("capture with zero did not clear count");
    AST_IGNORE_IRQ: assert property (ctrl_q[TMS_C_OVF] && mode_ext_q[TMS_X_IGN]
        && !ctrl_q[TMS_C_EXTF] && !(lovf_flag_q && lirq_en_q) |-> !timer_irq)
        else $error("ignored overflow raised interrupt");
    AST_LOW_FLAG: assert property (low_ovf |=> lovf_flag_q && timer_overflow)
        else $error("low overflow flag or pulse missing");

    COV_SPLIT_LOW_OVF: cover property (split && low_ovf ##1 timer_overflow);
    COV_CAPTURE: cover property (cap_evt && mode == TMS_CAPTURE);
    COV_CLKOUT: cover property (mode_q[TMS_M_CKOE] && ovf_evt ##1 $changed(ckout_q));
endmodule

// *** bench/tms_src_model.sv ***
// Behavioural model of the timer's event sources and port pins
`timescale 1ns/1ps
module tms_src_model (
    input wire logic clk, // System clock
    input wire logic [7:0] lvl, // Commanded trigger source levels
    input wire logic [1:0] route, // Pin pair now in use
    input wire logic [7:0] pin_out, // Levels the timer drives
    input wire logic [7:0] pin_oe, // Timer output enables
    input wire logic pulse_cmd, // Commanded internal event
    output logic [7:0] pin_in, // Resolved pin levels
    output logic event_pulse, // Internal event, one cycle after command
    output logic serial0_rx, // Serial 0 receive line
    output logic keypad_event, // Keypad event level
    output logic ext_int2_event, // External interrupt 2 level
    output logic serial1_rx, // Serial 1 receive line
    output logic comparator0_output, // Comparator 0 level
    output logic comparator1_output, // Comparator 1 level
    output logic twowire_clock_line // Two-wire clock line
);
    // Levels only move on command and are held many cycles, below half the clock
    always_comb begin
        serial0_rx = lvl[1];
        keypad_event = lvl[2];
        ext_int2_event = lvl[3];
        serial1_rx = lvl[4];
        comparator0_output = lvl[5];
        comparator1_output = lvl[6];
        twowire_clock_line = lvl[7];
    end
    // Internal event sources answer a command one clock later, one cycle wide
    always_ff @(posedge clk) begin
        event_pulse <= pulse_cmd;
    end
    // Pins have pull-ups; the routed trigger pin follows the commanded level
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            pin_in[2*k] = pin_oe[2*k] ? pin_out[2*k] : 1'b1;
            pin_in[2*k+1] = (k == int'(route)) ? lvl[0] : 1'b1;
        end
    end
endmodule

// *** bench/tms_timer_bench.sv ***
// Self-checking bench for the split-capable timer
`timescale 1ns/1ps
module tms_timer_bench;
    import tms_pkg::*;
    logic clk, arst_n, sfr_page, sfr_wr, sfr_rd, evp, pcmd, s0rx, kp, ei2, s1rx, c0o, c1o, twc;
    logic t_ovf, rxs, txs, irq;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pin_in, pin_out, pin_oe, lvl, v;
    logic [1:0] route;
    logic [24:0] rows[11];
    int n_fail, compares;
    tms_timer u_tms_timer (.clk(clk), .arst_n(arst_n), .sfr_page(sfr_page),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .port_pin_in(pin_in), .port_pin_out(pin_out),
        .port_pin_oe(pin_oe), .serial1_brg_overflow(evp), .ext_int0_event(evp),
        .ext_int2_event(ei2), .timer0_overflow(evp), .comparator0_event(evp),
        .keypad_event(kp), .serial0_rx(s0rx), .serial1_rx(s1rx), .comparator0_output(c0o),
        .comparator1_output(c1o), .twowire_clock_line(twc), .timer_overflow(t_ovf),
        .rx_clock_sel(rxs), .tx_clock_sel(txs), .timer_irq(irq));
    tms_src_model u_tms_src_model (.clk(clk), .lvl(lvl), .route(route), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in), .pulse_cmd(pcmd), .event_pulse(evp),
        .serial0_rx(s0rx),
        .keypad_event(kp), .ext_int2_event(ei2), .serial1_rx(s1rx), .comparator0_output(c0o),
        .comparator1_output(c1o), .twowire_clock_line(twc));
    // Verdict and end of run
    task summarize;
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task ck(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Register writes and reads, strobe held one cycle
    task wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #1;
        sfr_page = pg; sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
        @(posedge clk); #1;
        sfr_wr = 1'b0;
    endtask
    task rc(input logic pg, input logic [7:0] a, input logic [7:0] e, input string m);
        @(posedge clk); #1;
        sfr_page = pg; sfr_addr = a; sfr_rd = 1'b1;
        @(posedge clk); #1;
        sfr_rd = 1'b0;
        @(posedge clk); #1;
        v = sfr_rdata;
        ck(v, e, m);
    endtask
    task rc16(input logic [7:0] a, input logic [15:0] e, input string m);
        rc(TMS_PAGE_0, a, e[7:0], m);
        rc(TMS_PAGE_0, a + 8'h01, e[15:8], m);
    endtask
    task ld(input logic [15:0] cnt, input logic [15:0] rcap);
        wr(TMS_PAGE_0, TMS_ADDR_CNT_L, cnt[7:0]);
        wr(TMS_PAGE_0, TMS_ADDR_CNT_H, cnt[15:8]);
        wr(TMS_PAGE_0, TMS_ADDR_RCAP_L, rcap[7:0]);
        wr(TMS_PAGE_0, TMS_ADDR_RCAP_H, rcap[15:8]);
    endtask
    // One rising then falling pulse on a trigger source, each level held six cycles
    task fire(input int s);
        @(posedge clk); #1;
        lvl[s] = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        lvl[s] = 1'b0;
        repeat (6) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #3000000;
        n_fail++;
        summarize;
    end
    initial begin
        arst_n = 0; sfr_page = 0; sfr_addr = 0; sfr_wr = 0; sfr_rd = 0; sfr_wdata = 0;
        lvl = 0; route = 0; n_fail = 0; compares = 0; pcmd = 0;
        rows = '{{TMS_PAGE_1, TMS_ADDR_MODE_EXT, 16'h5A5A},
            {TMS_PAGE_1, TMS_ADDR_AUX_ROUTE, 16'h3F3F},
            {TMS_PAGE_0, TMS_ADDR_MODE, 16'h5C5C}, {TMS_PAGE_0, TMS_ADDR_RCAP_L, 16'hA5A5},
            {TMS_PAGE_0, TMS_ADDR_RCAP_H, 16'h5A5A}, {TMS_PAGE_0, TMS_ADDR_CNT_L, 16'h3C3C},
            {TMS_PAGE_0, TMS_ADDR_CNT_H, 16'hC3C3}, {TMS_PAGE_0, TMS_ADDR_CTRL, 16'h0909},
            {TMS_PAGE_0, TMS_ADDR_MODE_EXT, 16'h7700}, {TMS_PAGE_1, TMS_ADDR_MODE, 16'h7700},
            {TMS_PAGE_0, 8'hC7, 16'hFF00}};
        repeat (20) @(posedge clk);
        #1 arst_n = 1;
        foreach (rows[i]) begin
            wr(rows[i][24], rows[i][23:16], rows[i][15:8]);
            rc(rows[i][24], rows[i][23:16], rows[i][7:0], "readback");
        end
        // Every mode against one rising trigger edge, timer stopped
        wr(TMS_PAGE_1, TMS_ADDR_MODE_EXT, 8'h00);
        wr(TMS_PAGE_1, TMS_ADDR_AUX_ROUTE, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'(m >> 1));
            wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'h20 | 8'(m & 1));
            ld(16'hABCD, 16'h1234);
            fire(0);
            rc(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h40 | 8'(m >> 1), "ext flag");
            rc16(TMS_ADDR_CNT_L, m[0] ? (m[1] ? 16'h0000 : 16'h1234) : 16'hABCD, "cnt");
            rc16(TMS_ADDR_RCAP_L, (m >= 2) ? 16'hABCD : 16'h1234, "rcap");
        end
        // Every capture source, then the trigger pin on each routed pair
        wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'h20);
        for (int i = 0; i < 11; i++) begin
            route = (i < 8) ? 2'd0 : 2'(i - 7);
            wr(TMS_PAGE_1, TMS_ADDR_AUX_ROUTE, {route, 6'h00});
            wr(TMS_PAGE_1, TMS_ADDR_MODE_EXT, 8'((i < 8) ? i : 0));
            wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h01);
            ld(16'hABCD, 16'h0000);
            fire((i < 8) ? i : 0);
            rc16(TMS_ADDR_RCAP_L, 16'hABCD, "capture source");
        end
        // Serial clock use blocks capture but keeps the flag
        route = 0;
        wr(TMS_PAGE_1, TMS_ADDR_AUX_ROUTE, 8'h00);
        wr(TMS_PAGE_1, TMS_ADDR_MODE_EXT, 8'h00);
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h31);
        ld(16'hABCD, 16'h0000);
        fire(0);
        ck({6'h00, rxs, txs}, 8'h03, "serial clock sel");
        rc16(TMS_ADDR_RCAP_L, 16'h0000, "blocked capture");
        rc(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h71, "flag kept");
        ck({7'h00, irq}, 8'h01, "ext irq");
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h01);
        wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'h00);
        fire(0);
        rc(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h01, "rise ignored");
        // Clock-out enable lands on the routed pin
        for (int r = 0; r < 4; r++) begin
            route = 2'(r);
            wr(TMS_PAGE_1, TMS_ADDR_AUX_ROUTE, {route, 6'h00});
            wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'h02);
            ck(pin_oe, 8'(1 << (2 * r)), "clock out pin");
        end
        wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'h00);
        ck(pin_oe, 8'h00, "clock out off");
        // Sixteen-bit overflow on core clock, then with the interrupt ignored
        route = 0;
        wr(TMS_PAGE_1, TMS_ADDR_AUX_ROUTE, 8'h00);
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h00);
        wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'h12);
        ld(16'hFFF0, 16'h1234);
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h04);
        for (int k = 0; k < 100 && irq !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        ck({5'h00, pin_out[0], t_ovf, irq}, 8'h07, "overflow outputs");
        rc(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h84, "overflow flag");
        rc(TMS_PAGE_0, TMS_ADDR_CNT_H, 8'h12, "reloaded");
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h00);
        wr(TMS_PAGE_1, TMS_ADDR_MODE_EXT, 8'h40);
        ld(16'hFFF0, 16'h12F8);
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h04);
        repeat (40) @(posedge clk);
        #1;
        ck({7'h00, irq}, 8'h00, "ignored irq");
        rc(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h84, "flag still set");
        // Split: low byte on core clock, high byte stopped
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h00);
        wr(TMS_PAGE_1, TMS_ADDR_MODE_EXT, 8'h20);
        ld(16'h77F0, 16'h0005);
        wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'hC8);
        repeat (30) @(posedge clk);
        rc(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h20, "low overflow");
        ck({7'h00, irq}, 8'h00, "low irq masked");
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h30);
        ck({7'h00, irq}, 8'h01, "low irq shared");
        rc(TMS_PAGE_0, TMS_ADDR_CNT_H, 8'h77, "high byte held");
        wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'hC0);
        rc(TMS_PAGE_0, TMS_ADDR_CNT_L, 8'h1D, "low count at stop");
        repeat (5) @(posedge clk);
        rc(TMS_PAGE_0, TMS_ADDR_CNT_L, 8'h1D, "low stopped");
        // High-byte overflow clears the low run bit only when enabled
        for (int a = 0; a < 2; a++) begin
            wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h00);
            wr(TMS_PAGE_1, TMS_ADDR_MODE_EXT, 8'h00);
            ld(16'hFF00, 16'h0000);
            wr(TMS_PAGE_0, TMS_ADDR_MODE, (a == 0) ? 8'h9C : 8'h98);
            wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h04);
            repeat (10) @(posedge clk);
            rc(TMS_PAGE_0, TMS_ADDR_MODE, (a == 0) ? 8'h94 : 8'h98, "autoclear");
        end
        // Split halves both counting serial 1 baud pulses
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h00);
        wr(TMS_PAGE_1, TMS_ADDR_MODE_EXT, 8'h90);
        ld(16'h0000, 16'h0000);
        wr(TMS_PAGE_0, TMS_ADDR_MODE, 8'h88);
        wr(TMS_PAGE_0, TMS_ADDR_CTRL, 8'h04);
        repeat (5) begin
            @(posedge clk);
            #1 pcmd = 1'b1;
            @(posedge clk);
            #1 pcmd = 1'b0;
        end
        rc16(TMS_ADDR_CNT_L, 16'h0505, "event pulses");
        // Reset in mid-run returns registers to zero
        #1 arst_n = 0;
        repeat (3) @(posedge clk);
        #1 arst_n = 1;
        rc(TMS_PAGE_0, TMS_ADDR_MODE, 8'h00, "reset mode");
        rc(TMS_PAGE_1, TMS_ADDR_MODE_EXT, 8'h00, "reset ext");
        ck({pin_oe[6:0], irq}, 8'h00, "reset outputs");
        summarize;
    end
endmodule
